// [eirc_pkg.sv]
// Constants, states and carrier types of the external interrupt controller.
package eirc_pkg;

   localparam logic [7:0]  OFS_RESET_CAUSE  = 8'h34;
   localparam logic [7:0]  OFS_CORE_CONTROL = 8'h35;
   localparam logic [7:0]  OFS_FLAG         = 8'h3A;
   localparam logic [7:0]  OFS_ENABLE       = 8'h3B;
   localparam logic [7:0]  OFS_STATUS_WORD  = 8'h3F;

   // Bit positions of lines zero, one and two in enable and flag registers.
   localparam int          LINE_BIT [0:2]   = '{6, 7, 5};
   localparam logic [12:0] LINE_VECTOR [0:2] =
      '{13'h0002, 13'h0004, 13'h0006};

   localparam int          CAUSE_WDOG_BIT   = 3;
   localparam int          CAUSE_PIN_BIT    = 1;
   localparam int          CAUSE_POWER_BIT  = 0;
   localparam int          GIE_BIT          = 7;
   localparam int          LINE_TWO_EDGE_BIT = 4;

   localparam logic [3:0]  CAUSE_POR_VALUE  = 4'h1;
   localparam logic [7:0]  REG_RESET_VALUE  = 8'h00;

   localparam logic [1:0]  SENSE_LOW        = 2'b00;
   localparam logic [1:0]  SENSE_ANY        = 2'b01;
   localparam logic [1:0]  SENSE_FALL       = 2'b10;
   localparam logic [1:0]  SENSE_RISE       = 2'b11;

   localparam logic [2:0]  ENTRY_CYCLES     = 3'h4;
   localparam logic [2:0]  WAKE_CYCLES      = 3'h4;
   localparam logic [2:0]  RETURN_CYCLES    = 3'h4;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_WAKE   = 3'b001,
      ST_ENTRY  = 3'b010,
      ST_RETURN = 3'b011,
      ST_HOLD   = 3'b100
   } eirc_state_type;

   typedef struct packed {
      logic        instr_done;
      logic        sleeping;
      logic        return_from_handler_instr;
      logic [12:0] pc;
      logic [7:0]  pop_data;
   } eirc_core_in_type;

   typedef struct packed {
      logic        busy;
      logic        gie;
      logic        push;
      logic [7:0]  push_byte;
      logic        pop;
      logic        sp_add2;
      logic        pc_load;
      logic [12:0] pc_target;
   } eirc_core_out_type;

endpackage : eirc_pkg

// [eirc_ctrl.sv]
// External interrupt lines, entry and return sequencing, reset cause flags.
`timescale 1ns/1ps
`default_nettype none

module eirc_ctrl (
   input  wire logic                       clk,
   input  wire logic                       rstn,
   input  wire logic                       por_rstn,
   input  wire logic [7:0]                 addr,
   input  wire logic [7:0]                 wr_data,
   input  wire logic                       wr_en,
   input  wire logic                       rd_en,
   output logic      [7:0]                 rd_data,
   input  wire logic [2:0]                 ext_pin,
   input  wire logic                       wdog_reset_evt,
   input  wire logic                       pin_reset_evt,
   input  wire eirc_pkg::eirc_core_in_type  core_in,
   output eirc_pkg::eirc_core_out_type      core_out
);

   eirc_pkg::eirc_state_type    state_q;
   eirc_pkg::eirc_state_type    state_d;
   eirc_pkg::eirc_core_out_type cout_q;
   eirc_pkg::eirc_core_out_type cout_d;
   logic [2:0]  cnt_q;
   logic [2:0]  cnt_d;
   logic [2:0]  flag_q;
   logic [2:0]  enable_q;
   logic [4:0]  ctrl_q;
   logic        gie_q;
   logic        gie_d;
   logic [2:0]  prev_q;
   logic [1:0]  sel_q;
   logic [12:0] pc_save_q;
   logic [7:0]  ret_hi_q;
   logic [7:0]  rd_data_q;
   logic        wdog_seen_q;
   logic        pin_seen_q;
   logic        power_seen_q;

   // Register decode.
   wire wr_flag   = wr_en & (addr == eirc_pkg::OFS_FLAG);
   wire wr_enable = wr_en & (addr == eirc_pkg::OFS_ENABLE);
   wire wr_cause  = wr_en & (addr == eirc_pkg::OFS_RESET_CAUSE);
   wire wr_ctrl   = wr_en & (addr == eirc_pkg::OFS_CORE_CONTROL);
   wire wr_status = wr_en & (addr == eirc_pkg::OFS_STATUS_WORD);

   // Per-line sense codes; line two only knows rising or falling edges.
   logic [1:0] sense_code [0:2];
   assign sense_code[0] = ctrl_q[1:0];
   assign sense_code[1] = ctrl_q[3:2];
   assign sense_code[2] = {1'b1, ctrl_q[eirc_pkg::LINE_TWO_EDGE_BIT]};

   // Last entry cycle: the vector is loaded and the served flag cleared.
   wire       hw_clear = (state_q == eirc_pkg::ST_ENTRY) &
                         (cnt_q == eirc_pkg::ENTRY_CYCLES - 3'h1);
   logic [2:0] req;
   logic [2:0] fire;

   // The pin is read directly, so an output-driven pin still triggers.
   genvar i;
   generate
      for (i = 0; i < 3; i++) begin : g_line
         wire rise  = ext_pin[i] & ~prev_q[i];
         wire fall  = ~ext_pin[i] & prev_q[i];
         wire level = (sense_code[i] == eirc_pkg::SENSE_LOW);
         wire hit   = ((sense_code[i] == eirc_pkg::SENSE_ANY) & (rise | fall))
                    | ((sense_code[i] == eirc_pkg::SENSE_FALL) & fall)
                    | ((sense_code[i] == eirc_pkg::SENSE_RISE) & rise);
         wire sw_clr = wr_flag & wr_data[eirc_pkg::LINE_BIT[i]];
         wire hw_clr = hw_clear & (sel_q == 2'(i));
         // A new edge wins over any clear in the same cycle.
         wire flag_d = hit | (flag_q[i] & ~sw_clr & ~hw_clr);
         // In level mode the request follows the pin and bypasses the flag.
         assign req[i]  = level ? ~ext_pin[i] : flag_q[i];
         assign fire[i] = req[i] & enable_q[i];

         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               flag_q[i] <= 1'b0;
            end else begin
               flag_q[i] <= flag_d;
            end
         end
      end
   endgenerate

   // Lowest vector address first: line zero, then one, then two.
   wire [1:0] sel_d   = fire[0] ? 2'd0 : (fire[1] ? 2'd1 : 2'd2);
   wire       any_fire = |fire;
   wire       at_boundary = core_in.instr_done |
                            (core_in.sleeping & (state_q == eirc_pkg::ST_IDLE));
   wire       may_accept = (state_q == eirc_pkg::ST_IDLE) |
                           (state_q == eirc_pkg::ST_HOLD);
   // Entry waits for the end of the running instruction.
   wire       accept = may_accept & at_boundary & gie_q & any_fire &
                       ~core_in.return_from_handler_instr;
   wire       wake   = accept & core_in.sleeping &
                       ~core_in.instr_done;

   // Sequencer.
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q + 3'h1;
      case (state_q)
         eirc_pkg::ST_IDLE: begin
            cnt_d = 3'h0;
            if (core_in.return_from_handler_instr) begin
               state_d = eirc_pkg::ST_RETURN;
            end else if (wake) begin
               state_d = eirc_pkg::ST_WAKE;
            end else if (accept) begin
               state_d = eirc_pkg::ST_ENTRY;
            end
         end
         // Wake stretches the entry by the start-up cycles of the core.
         eirc_pkg::ST_WAKE: begin
            if (cnt_q == eirc_pkg::WAKE_CYCLES - 3'h1) begin
               state_d = eirc_pkg::ST_ENTRY;
               cnt_d   = 3'h0;
            end
         end
         eirc_pkg::ST_ENTRY: begin
            if (cnt_q == eirc_pkg::ENTRY_CYCLES - 3'h1) begin
               state_d = eirc_pkg::ST_IDLE;
               cnt_d   = 3'h0;
            end
         end
         // Return pops the high byte first, then the low byte.
         eirc_pkg::ST_RETURN: begin
            if (cnt_q == eirc_pkg::RETURN_CYCLES - 3'h1) begin
               state_d = eirc_pkg::ST_HOLD;
               cnt_d   = 3'h0;
            end
         end
         // Hold lets one main instruction retire before the next entry.
         eirc_pkg::ST_HOLD: begin
            cnt_d = 3'h0;
            if (accept) begin
               state_d = eirc_pkg::ST_ENTRY;
            end else if (core_in.instr_done) begin
               state_d = eirc_pkg::ST_IDLE;
            end
         end
         default: begin
            state_d = eirc_pkg::ST_IDLE;
            cnt_d   = 3'h0;
         end
      endcase
   end

   // Global enable: cleared on acceptance, set by the return sequence.
   // The status word is left to software; only the enable bit lives here.
   always_comb begin
      gie_d = gie_q;
      if (accept) begin
         gie_d = 1'b0;
      end else if ((state_q == eirc_pkg::ST_RETURN) &&
                   (cnt_q == eirc_pkg::RETURN_CYCLES - 3'h1)) begin
         gie_d = 1'b1;
      end else if (wr_status) begin
         gie_d = wr_data[eirc_pkg::GIE_BIT];
      end
   end

   // Core-facing outputs; all are registered.
   wire in_entry  = (state_q == eirc_pkg::ST_ENTRY);
   wire in_return = (state_q == eirc_pkg::ST_RETURN);
   always_comb begin
      cout_d           = '0;
      cout_d.busy      = (state_d != eirc_pkg::ST_IDLE) &
                         (state_d != eirc_pkg::ST_HOLD);
      cout_d.gie       = gie_d;
      cout_d.push      = in_entry & ((cnt_q == 3'h1) | (cnt_q == 3'h2));
      // The low byte of the counter is pushed first, the high byte second.
      cout_d.push_byte = (cnt_q == 3'h1) ? pc_save_q[7:0]
                                         : {3'b000, pc_save_q[12:8]};
      cout_d.pop       = in_return & ((cnt_q == 3'h0) | (cnt_q == 3'h1));
      cout_d.sp_add2   = in_return & (cnt_q == 3'h3);
      if (hw_clear) begin
         cout_d.pc_load   = 1'b1;
         cout_d.pc_target = eirc_pkg::LINE_VECTOR[sel_q];
      end else if (in_return && (cnt_q == 3'h3)) begin
         cout_d.pc_load   = 1'b1;
         cout_d.pc_target = {ret_hi_q[4:0], core_in.pop_data};
      end
   end

   // Sequencer state and step counter.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= eirc_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 3'h0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // Every core-facing output leaves from this register.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cout_q <= '0;
      end else begin
         cout_q <= cout_d;
      end
   end

   // Global enable bit of the status word.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gie_q <= 1'b0;
      end else begin
         gie_q <= gie_d;
      end
   end

   // Previous pin levels start low, like idle pins, so that no false
   // edge is seen right after reset.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prev_q <= 3'b000;
      end else begin
         prev_q <= ext_pin;
      end
   end

   // The served line is latched at acceptance, so a later edge on a
   // higher priority line cannot redirect a vector already under way.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sel_q <= 2'd0;
      end else if (accept) begin
         sel_q <= sel_d;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pc_save_q <= 13'h0000;
      end else if (accept) begin
         pc_save_q <= core_in.pc;
      end
   end

   // The high return byte stands on the pop bus in the third return cycle.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ret_hi_q <= 8'h00;
      end else if (in_return && (cnt_q == 3'h2)) begin
         ret_hi_q <= core_in.pop_data;
      end
   end

   // Line enables, packed in line order zero, one, two.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         enable_q <= 3'b000;
      end else if (wr_enable) begin
         enable_q <= {wr_data[eirc_pkg::LINE_BIT[2]],
                      wr_data[eirc_pkg::LINE_BIT[1]],
                      wr_data[eirc_pkg::LINE_BIT[0]]};
      end
   end

   // Sense control: two bits each for lines zero and one, one for two.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= 5'h00;
      end else if (wr_ctrl) begin
         ctrl_q <= wr_data[4:0];
      end
   end

   // Reset cause flags sit on the power-on reset only, so they survive
   // the pin and watchdog resets that they record. An event wins over a
   // clearing write in the same cycle.
   // Writing a one leaves a cause flag as it is.
   wire clr_wdog  = wr_cause & ~wr_data[eirc_pkg::CAUSE_WDOG_BIT];
   wire clr_pin   = wr_cause & ~wr_data[eirc_pkg::CAUSE_PIN_BIT];
   wire clr_power = wr_cause & ~wr_data[eirc_pkg::CAUSE_POWER_BIT];
   always_ff @(posedge clk or negedge por_rstn) begin
      if (!por_rstn) begin
         wdog_seen_q <= eirc_pkg::CAUSE_POR_VALUE[eirc_pkg::CAUSE_WDOG_BIT];
      end else begin
         wdog_seen_q <= wdog_reset_evt | (wdog_seen_q & ~clr_wdog);
      end
   end

   always_ff @(posedge clk or negedge por_rstn) begin
      if (!por_rstn) begin
         pin_seen_q <= eirc_pkg::CAUSE_POR_VALUE[eirc_pkg::CAUSE_PIN_BIT];
      end else begin
         pin_seen_q <= pin_reset_evt | (pin_seen_q & ~clr_pin);
      end
   end

   // The power-on flag is set by power-on reset; only software clears it.
   always_ff @(posedge clk or negedge por_rstn) begin
      if (!por_rstn) begin
         power_seen_q <= eirc_pkg::CAUSE_POR_VALUE[eirc_pkg::CAUSE_POWER_BIT];
      end else begin
         power_seen_q <= power_seen_q & ~clr_power;
      end
   end

   // Read path; unmapped addresses and reserved bits read zero.
   logic [7:0] flag_view;
   logic [7:0] enable_view;
   always_comb begin
      flag_view   = eirc_pkg::REG_RESET_VALUE;
      enable_view = eirc_pkg::REG_RESET_VALUE;
      for (int k = 0; k < 3; k++) begin
         flag_view[eirc_pkg::LINE_BIT[k]]   = flag_q[k];
         enable_view[eirc_pkg::LINE_BIT[k]] = enable_q[k];
      end
   end
   wire [7:0] cause_view = {4'h0, wdog_seen_q, 1'b0, pin_seen_q,
                            power_seen_q};
   wire [7:0] rd_mux =
      (addr == eirc_pkg::OFS_FLAG)         ? flag_view :
      (addr == eirc_pkg::OFS_ENABLE)       ? enable_view :
      (addr == eirc_pkg::OFS_RESET_CAUSE)  ? cause_view :
      (addr == eirc_pkg::OFS_CORE_CONTROL) ? {3'b000, ctrl_q} :
      (addr == eirc_pkg::OFS_STATUS_WORD)  ? {gie_q, 7'h00} :
                                             8'h00;

   // Read data stays zero outside the cycle after a read strobe.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_data_q <= 8'h00;
      end else begin
         rd_data_q <= rd_en ? rd_mux : 8'h00;
      end
   end

   assign rd_data  = rd_data_q;
   assign core_out = cout_q;

endmodule : eirc_ctrl

`default_nettype wire

// [eirc_ctrl_asserts.sv]
// Port-level assertions for the external interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module eirc_ctrl_asserts (
   input wire logic                        clk,
   input wire logic                        rstn,
   input wire logic                        por_rstn,
   input wire logic [7:0]                  addr,
   input wire logic [7:0]                  wr_data,
   input wire logic                        wr_en,
   input wire logic                        rd_en,
   input wire logic [7:0]                  rd_data,
   input wire logic [2:0]                  ext_pin,
   input wire logic                        wdog_reset_evt,
   input wire logic                        pin_reset_evt,
   input wire eirc_pkg::eirc_core_in_type  core_in,
   input wire eirc_pkg::eirc_core_out_type core_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   rd_idle_a: assert property (!$past(rd_en) |-> rd_data == 8'h00)
      else $error("read data not zero outside a read");
   flag_rsvd_a: assert property ($past(rd_en) &&
      ($past(addr) == eirc_pkg::OFS_FLAG || $past(addr) == eirc_pkg::OFS_ENABLE)
      |-> rd_data[4:0] == 5'h00) else $error("flag or enable low bits set");
   cause_rsvd_a: assert property ($past(rd_en) &&
      $past(addr) == eirc_pkg::OFS_RESET_CAUSE
      |-> rd_data[7:4] == 4'h0 && !rd_data[2]) else $error("cause reserved set");
   accept_gie_a: assert property ($rose(core_out.busy) &&
      !$past(core_in.return_from_handler_instr) |-> !core_out.gie)
      else $error("global enable still set after accept");
   need_gie_a: assert property ($rose(core_out.busy) &&
      !$past(core_in.return_from_handler_instr) &&
      !$past(core_in.return_from_handler_instr, 2) |-> $past(core_out.gie))
      else $error("accept no gie");
   push_pair_a: assert property ($rose(core_out.push) |=> core_out.push &&
      core_out.push_byte[7:5] == 3'h0 ##1 core_out.pc_load) else $error("bad push");
   entry_len_a: assert property (core_out.pc_load && $past(core_out.push)
      |-> $past(core_out.busy, 4)) else $error("entry shorter than four cycles");
   vector_a: assert property (core_out.pc_load && $past(core_out.push) |->
      core_out.pc_target inside {13'h0002, 13'h0004, 13'h0006})
      else $error("vector address unknown");
   pop_pair_a: assert property ($rose(core_out.pop) |=> core_out.pop ##2
      core_out.sp_add2 && core_out.pc_load) else $error("bad return sequence");
   ret_gie_a: assert property (core_out.sp_add2 |-> ##[0:1] core_out.gie)
      else $error("global enable not set on return");
endmodule : eirc_ctrl_asserts

bind eirc_ctrl eirc_ctrl_asserts u_chk (.clk(clk), .rstn(rstn),
   .por_rstn(por_rstn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
   .rd_en(rd_en), .rd_data(rd_data), .ext_pin(ext_pin),
   .wdog_reset_evt(wdog_reset_evt), .pin_reset_evt(pin_reset_evt),
   .core_in(core_in), .core_out(core_out));
`default_nettype wire

// [eirc_core_model.sv]
// Behavioural processor core with a byte stack, facing the controller.
`timescale 1ns/1ps
`default_nettype none
module eirc_core_model #(
   parameter logic [12:0] PC_START = 13'h0A5C
) (
   input wire logic                        clk,
   input wire logic                        rstn,
   input wire logic                        step,
   input wire logic                        slp,
   input wire logic                        ret,
   input wire eirc_pkg::eirc_core_out_type core_out,
   output eirc_pkg::eirc_core_in_type      core_in
);
   logic [7:0]  mem [0:15];
   logic [3:0]  sp_q;
   logic [12:0] pc_q;
   logic [7:0]  pop_q;
   assign core_in = '{instr_done: step, sleeping: slp,
                      return_from_handler_instr: ret,
                      pc: pc_q, pop_data: pop_q};
   // Only the counter bytes travel on the stack; status is left to software.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sp_q  <= 4'hF;
         pc_q  <= PC_START;
         pop_q <= 8'h00;
      end else begin
         if (core_out.push) begin
            mem[sp_q] <= core_out.push_byte;
            sp_q      <= sp_q - 4'h1;
         end
         // An idle pop bus toggles so a stale byte never looks valid.
         if (core_out.pop) begin
            pop_q <= mem[sp_q + 4'h1];
            sp_q  <= sp_q + 4'h1;
         end else pop_q <= ~pop_q;
         if (core_out.pc_load) pc_q <= core_out.pc_target;
      end
   end
endmodule : eirc_core_model
`default_nettype wire

// [tb_top.sv]
// Self-checking testbench for the external interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [12:0] PC0 = 13'h0A5C;
   logic       clk, rstn, por_rstn, wr_en, rd_en, wdog, pin_evt, step, slp, ret;
   logic [7:0] addr, wr_data, rd_data;
   logic [2:0] ext_pin;
   logic [12:0] exp_pc, ret_pc;
   int          err_count, n_checks, cyc;
   eirc_pkg::eirc_core_in_type  core_in;
   eirc_pkg::eirc_core_out_type core_out;

   eirc_ctrl dut (.clk(clk), .rstn(rstn), .por_rstn(por_rstn), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .ext_pin(ext_pin), .wdog_reset_evt(wdog), .pin_reset_evt(pin_evt),
      .core_in(core_in), .core_out(core_out));
   eirc_core_model #(.PC_START(PC0)) u_core (.clk(clk), .rstn(rstn),
      .step(step), .slp(slp), .ret(ret), .core_out(core_out), .core_in(core_in));

   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         print_verdict();
      end
   end

   task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a; wr_data <= d; wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a; rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(negedge clk);
      chk("register", {5'h00, e}, {5'h00, rd_data});
   endtask : rd
   task automatic no_accept(input logic s);
      @(posedge clk);
      step <= s;
      @(posedge clk);
      step <= 1'b0;
      repeat (3) begin
         @(negedge clk);
         chk("busy", 13'h0000, {12'h000, core_out.busy});
      end
   endtask : no_accept
   task automatic serve(input logic s, input logic [12:0] vec, input logic [12:0] lat);
      int n;
      logic [7:0] q[$];
      n = 0;
      @(posedge clk);
      if (s) slp <= 1'b1;
      else step <= 1'b1;
      @(posedge clk);
      step <= 1'b0;
      while (!core_out.pc_load && n < 20) begin
         @(negedge clk);
         n++;
         if (core_out.push) q.push_back(core_out.push_byte);
      end
      chk("latency", lat, 13'(n));
      chk("vector", vec, core_out.pc_target);
      chk("push low", {5'h00, exp_pc[7:0]}, {5'h00, q[0]});
      chk("push high", {8'h00, exp_pc[12:8]}, {5'h00, q[1]});
      chk("gie", 13'h0000, {12'h000, core_out.gie});
      ret_pc = exp_pc;
      exp_pc = vec;
      @(posedge clk);
      slp <= 1'b0;
   endtask : serve
   task automatic ret_chk;
      int n;
      n = 0;
      @(posedge clk);
      ret <= 1'b1;
      @(posedge clk);
      ret <= 1'b0;
      while (!core_out.sp_add2 && n < 20) begin
         @(negedge clk);
         n++;
      end
      chk("return pc", ret_pc, core_out.pc_target);
      @(negedge clk);
      chk("gie", 13'h0001, {12'h000, core_out.gie});
      chk("stack ptr", 13'h000F, {9'h000, u_core.sp_q});
      exp_pc = ret_pc;
      no_accept(1'b0);
   endtask : ret_chk

   task automatic t_regs;
      rd(eirc_pkg::OFS_FLAG, 8'h00);
      rd(eirc_pkg::OFS_ENABLE, 8'h00);
      rd(eirc_pkg::OFS_RESET_CAUSE, 8'h01);
      rd(8'h20, 8'h00);
   endtask : t_regs
   task automatic t_cause;
      @(posedge clk) rstn <= 1'b0;
      @(posedge clk) rstn <= 1'b1;
      rd(eirc_pkg::OFS_RESET_CAUSE, 8'h01);
      @(posedge clk) {wdog, pin_evt} <= 2'b11;
      @(posedge clk) {wdog, pin_evt} <= 2'b00;
      rd(eirc_pkg::OFS_RESET_CAUSE, 8'h0B);
      wr(eirc_pkg::OFS_RESET_CAUSE, 8'hFF);
      rd(eirc_pkg::OFS_RESET_CAUSE, 8'h0B);
      wr(eirc_pkg::OFS_RESET_CAUSE, 8'h00);
      rd(eirc_pkg::OFS_RESET_CAUSE, 8'h00);
      @(posedge clk) wdog <= 1'b1;
      @(posedge clk) {wdog, rstn, por_rstn} <= 3'b000;
      @(posedge clk) {rstn, por_rstn} <= 2'b11;
      rd(eirc_pkg::OFS_RESET_CAUSE, 8'h01);
   endtask : t_cause
   task automatic t_edge;
      wr(eirc_pkg::OFS_CORE_CONTROL, 8'h1F);
      @(posedge clk) ext_pin <= 3'b111;
      @(posedge clk) ext_pin <= 3'b000;
      rd(eirc_pkg::OFS_FLAG, 8'hE0);
      wr(eirc_pkg::OFS_FLAG, 8'h40);
      rd(eirc_pkg::OFS_FLAG, 8'hA0);
      wr(eirc_pkg::OFS_ENABLE, 8'hFF);
      rd(eirc_pkg::OFS_ENABLE, 8'hE0);
      no_accept(1'b1);
      wr(eirc_pkg::OFS_STATUS_WORD, 8'h80);
      serve(1'b0, 13'h0004, 13'h0005);
      rd(eirc_pkg::OFS_FLAG, 8'h20);
      ret_chk();
      serve(1'b0, 13'h0006, 13'h0005);
      ret_chk();
   endtask : t_edge
   task automatic t_level;
      no_accept(1'b1);
      @(posedge clk) ext_pin <= 3'b001;
      wr(eirc_pkg::OFS_FLAG, 8'h40);
      wr(eirc_pkg::OFS_CORE_CONTROL, 8'h1C);
      @(posedge clk) ext_pin <= 3'b000;
      rd(eirc_pkg::OFS_FLAG, 8'h00);
      serve(1'b1, 13'h0002, 13'h0009);
      @(posedge clk) ext_pin <= 3'b001;
      ret_chk();
   endtask : t_level
   task automatic t_sense;
      wr(eirc_pkg::OFS_CORE_CONTROL, 8'h06);
      @(posedge clk) ext_pin <= 3'b111;
      rd(eirc_pkg::OFS_FLAG, 8'h80);
      @(posedge clk) ext_pin <= 3'b000;
      rd(eirc_pkg::OFS_FLAG, 8'hE0);
      wr(eirc_pkg::OFS_FLAG, 8'hE0);
      rd(eirc_pkg::OFS_FLAG, 8'h00);
   endtask : t_sense

   task automatic print_verdict;
      $display("Checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict

   initial begin
      clk = 0; rstn = 0; por_rstn = 0; addr = 0; wr_data = 0; wr_en = 0;
      rd_en = 0; ext_pin = 0; wdog = 0; pin_evt = 0; step = 0; slp = 0;
      ret = 0; err_count = 0; n_checks = 0; cyc = 0; exp_pc = PC0; ret_pc = PC0;
      repeat (8) @(posedge clk);
      {rstn, por_rstn} <= 2'b11;
      t_regs();
      t_cause();
      t_edge();
      t_level();
      t_sense();
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
